//--- rpci_ctl.sv
// Behaviour
// R1: Three-bit record source routes each ADC channel
// R2: Alternate group picks microphone selector source set
// R3: Dual-mic sends first left, second right
// R4: Mic sum adds both sources, ignores dual/swap
// R5: Swap picks second source or exchanges sides
// R6: Mono output from mono mixer or selector left
// R7: Four-bit ADC gain plus overriding mute
// R8: ADC gain resets to 0x8080
// R9: Software reads general-purpose before masked write
// R10: Loopback feeds ADC to DAC, reset off
// R11: Double-rate slot pair 10/11 or 7/8
// R12: Page field selects 0x60-0x6F page
// R13: Unimplemented page reads back differently
// R14: Interrupt enable masks interrupt, reset masked
// R15: Software keeps interrupt masked or polls
// R16: Sense bit starts, aborts, reads running
// R17: Cause bits show sense or GPIO change
// R18: Cause bits clear with interrupt status
// R19: Status cleared by writing one only
// R20: Slot-12 indication follows status when enabled
// R21: Reserved bits ignore writes, read zero
// R22: Record source resets zero, fields 10:8, 2:0
//
// The strobed register port was left to the implementer.
module rpci_ctl #(
  parameter int SENSE_CYCLES = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Asynchronous event inputs
  input wire logic gpio_change_in,
  // Record path, paging, sense and interrupt outputs
  output rpci_pkg::rpci_chan_s left_chan,
  output rpci_pkg::rpci_chan_s right_chan,
  output logic mono_from_mic,
  output logic adc_to_dac_loop,
  output logic [1:0] double_rate_slot_pair,
  output logic [3:0] page_select,
  output logic sense_active,
  output logic slot12_irq
);
  logic [15:0] rec_src_q, adc_gain_q, gp_ctl_q, mic_cfg_q;
  logic [3:0] page_q;
  logic unmask_q, sense_q, cause_s_q, cause_g_q, pend_q;
  logic [15:0] sense_cnt_q;
  logic gp_s1_q, gp_s2_q, gp_s3_q;
  logic wr_src, wr_gain, wr_gp, wr_mic, wr_irq;
  logic sense_end, gpio_evt, pend_clr, set_s, set_g;
  logic [15:0] rd_d;
  logic [5:0] first_t, second_t, sum_t, pick_l, pick_r;
  logic [2:0] alt_grp;
  logic swap, dual, msum;

  assign wr_src = reg_wr && reg_addr == rpci_pkg::ADDR_REC_SRC;
  assign wr_gain = reg_wr && reg_addr == rpci_pkg::ADDR_ADC_GAIN;
  assign wr_gp = reg_wr && reg_addr == rpci_pkg::ADDR_GP_CTL;
  assign wr_mic = reg_wr && reg_addr == rpci_pkg::ADDR_MIC_CFG;
  assign wr_irq = reg_wr && reg_addr == rpci_pkg::ADDR_IRQ_PAGE;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rec_src_q <= rpci_pkg::RST_REC_SRC; // R22
    end else if (wr_src) begin
      rec_src_q <= reg_wdata & rpci_pkg::MASK_REC_SRC; // R21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      adc_gain_q <= rpci_pkg::RST_ADC_GAIN; // R8
    end else if (wr_gain) begin
      adc_gain_q <= reg_wdata & rpci_pkg::MASK_ADC_GAIN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gp_ctl_q <= rpci_pkg::RST_GP_CTL; // R10
    end else if (wr_gp) begin
      gp_ctl_q <= reg_wdata & rpci_pkg::MASK_GP_CTL; // R21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mic_cfg_q <= rpci_pkg::RST_MIC_CFG;
    end else if (wr_mic) begin
      mic_cfg_q <= reg_wdata & rpci_pkg::MASK_MIC_CFG;
    end
  end

  // Pages 0 and 1 only; others fall back to vendor page
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      page_q <= rpci_pkg::PAGE_VENDOR; // R12
    end else if (wr_irq) begin
      if (reg_wdata[3:0] == rpci_pkg::PAGE_STD) begin
        page_q <= rpci_pkg::PAGE_STD; // R12
      end else begin
        page_q <= rpci_pkg::PAGE_VENDOR; // R13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unmask_q <= 1'b0; // R14
    end else if (wr_irq) begin
      unmask_q <= reg_wdata[rpci_pkg::POS_UNMASK];
    end
  end

  // Sense cycle timer
  assign sense_end = sense_q && sense_cnt_q == 16'(SENSE_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sense_q <= 1'b0;
      sense_cnt_q <= 16'h0000;
    end else if (wr_irq) begin
      sense_q <= reg_wdata[rpci_pkg::POS_SENSE]; // R16
      sense_cnt_q <= 16'h0000;
    end else if (sense_end) begin
      sense_q <= 1'b0; // R16
      sense_cnt_q <= 16'h0000;
    end else if (sense_q) begin
      sense_cnt_q <= sense_cnt_q + 16'h0001;
    end
  end

  // GPIO change synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gp_s1_q <= 1'b0;
      gp_s2_q <= 1'b0;
      gp_s3_q <= 1'b0;
    end else begin
      gp_s1_q <= gpio_change_in;
      gp_s2_q <= gp_s1_q;
      gp_s3_q <= gp_s2_q;
    end
  end
  assign gpio_evt = gp_s2_q && !gp_s3_q;

  // Status and causes; new events win over a clear
  assign pend_clr = wr_irq && reg_wdata[rpci_pkg::POS_PENDING]; // R19
  assign set_s = sense_end;
  assign set_g = gpio_evt;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      cause_s_q <= 1'b0;
      cause_g_q <= 1'b0;
    end else begin
      pend_q <= set_s || set_g || (pend_q && !pend_clr); // R19
      cause_s_q <= set_s || (cause_s_q && !pend_clr); // R17 R18
      cause_g_q <= set_g || (cause_g_q && !pend_clr); // R17 R18
    end
  end

  // Microphone selector term sets: {lfe,center,line_r,line_l,mic2,mic1}
  assign alt_grp = mic_cfg_q[rpci_pkg::POS_ALT_GRP +: 3];
  assign msum = mic_cfg_q[rpci_pkg::POS_MIC_SUM];
  assign dual = mic_cfg_q[rpci_pkg::POS_DUAL];
  assign swap = gp_ctl_q[rpci_pkg::POS_SWAP];
  always_comb begin
    first_t = 6'h01;
    second_t = 6'h02;
    case (alt_grp) // R2
      3'h0: begin
        first_t = 6'h01;
        second_t = 6'h02;
      end
      3'h1: begin
        first_t = 6'h04;
        second_t = 6'h08;
      end
      3'h2, 3'h3: begin
        first_t = 6'h10;
        second_t = 6'h20;
      end
      3'h4: begin
        first_t = 6'h11;
        second_t = 6'h22;
      end
      3'h5: begin
        first_t = 6'h05;
        second_t = 6'h0a;
      end
      3'h6: begin
        first_t = 6'h14;
        second_t = 6'h28;
      end
      default: begin
        first_t = 6'h15;
        second_t = 6'h2a;
      end
    endcase
  end
  assign sum_t = first_t | second_t;

  always_comb begin
    if (msum) begin
      pick_l = sum_t; // R4
      pick_r = sum_t;
    end else if (dual) begin
      pick_l = swap ? second_t : first_t; // R3 R5
      pick_r = swap ? first_t : second_t;
    end else begin
      pick_l = swap ? second_t : first_t; // R5
      pick_r = pick_l;
    end
  end

  // Read mux; unmapped reads give zero
  always_comb begin
    case (reg_addr)
      rpci_pkg::ADDR_REC_SRC: rd_d = rec_src_q;
      rpci_pkg::ADDR_ADC_GAIN: rd_d = adc_gain_q;
      rpci_pkg::ADDR_GP_CTL: rd_d = gp_ctl_q;
      rpci_pkg::ADDR_MIC_CFG: rd_d = mic_cfg_q;
      rpci_pkg::ADDR_IRQ_PAGE: rd_d = {pend_q, cause_g_q, cause_s_q, sense_q,
                                       unmask_q, 7'h00, page_q}; // R21
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Registered path outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      left_chan <= rpci_pkg::rpci_chan_s'(14'h2000); // R8
      right_chan <= rpci_pkg::rpci_chan_s'(14'h2000); // R8
      mono_from_mic <= 1'b0;
      adc_to_dac_loop <= 1'b0;
      double_rate_slot_pair <= 2'h0;
      page_select <= 4'h0;
      sense_active <= 1'b0;
      slot12_irq <= 1'b0;
    end else begin
      left_chan.src <= rpci_pkg::rpci_src_e'(rec_src_q[rpci_pkg::POS_LEFT_SRC +: 3]); // R1
      right_chan.src <= rpci_pkg::rpci_src_e'(rec_src_q[rpci_pkg::POS_RIGHT_SRC +: 3]); // R1
      left_chan.mute <= adc_gain_q[rpci_pkg::POS_LEFT_MUTE]; // R7
      left_chan.gain <= adc_gain_q[rpci_pkg::POS_LEFT_GAIN +: 4];
      right_chan.mute <= adc_gain_q[rpci_pkg::POS_RIGHT_MUTE]; // R7
      right_chan.gain <= adc_gain_q[rpci_pkg::POS_RIGHT_GAIN +: 4];
      left_chan.mic_terms <= pick_l;
      right_chan.mic_terms <= pick_r;
      mono_from_mic <= gp_ctl_q[rpci_pkg::POS_MONO_SEL]; // R6
      adc_to_dac_loop <= gp_ctl_q[rpci_pkg::POS_LOOP]; // R10
      double_rate_slot_pair <= gp_ctl_q[rpci_pkg::POS_DOUBLE_RATE_SLOT_PAIR +: 2]; // R11
      page_select <= page_q;
      sense_active <= sense_q;
      slot12_irq <= unmask_q && pend_q; // R14 R20
    end
  end

  a_pend_cause: assert property (@(posedge clk) disable iff (!rst_b)
    pend_q |-> (cause_s_q || cause_g_q)) else $error("status without cause"); // R17
  a_cause_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (pend_clr && !set_s && !set_g) |=> (!pend_q && !cause_s_q && !cause_g_q))
    else $error("causes not cleared"); // R18
  a_zero_noop: assert property (@(posedge clk) disable iff (!rst_b)
    (pend_q && !pend_clr) |=> pend_q) else $error("status lost without clear"); // R19
  a_irq_follow: assert property (@(posedge clk) disable iff (!rst_b)
    slot12_irq == $past(unmask_q && pend_q)) else $error("slot12 wrong"); // R20
  a_sense_run: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_irq && reg_wdata[rpci_pkg::POS_SENSE]) |=> sense_q ##1 (sense_q || $past(wr_irq)))
    else $error("sense not running"); // R16
  a_sense_abort: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_irq && !reg_wdata[rpci_pkg::POS_SENSE]) |=> !sense_q)
    else $error("abort failed"); // R16
  a_page_bad: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_irq && reg_wdata[3:0] > rpci_pkg::PAGE_STD) |=> page_q != $past(reg_wdata[3:0]))
    else $error("bad page echoed"); // R13
  a_rd_late: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == rpci_pkg::ADDR_ADC_GAIN && !reg_wr) |=> reg_rdata == $past(adc_gain_q))
    else $error("gain read wrong"); // R7
  a_loop_out: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_gp && reg_wdata[rpci_pkg::POS_LOOP]) |-> ##2 adc_to_dac_loop)
    else $error("loop not set"); // R10
  a_sum_mode: assert property (@(posedge clk) disable iff (!rst_b)
    msum |-> (pick_l == sum_t && pick_r == sum_t)) else $error("sum wrong"); // R4

  // Channel outputs follow their registers one cycle later
  a_src_left: assert property (@(posedge clk) disable iff (!rst_b) // R1
    left_chan.src == $past(rec_src_q[rpci_pkg::POS_LEFT_SRC +: 3]))
    else $error("left source wrong");
  a_src_right: assert property (@(posedge clk) disable iff (!rst_b) // R1
    right_chan.src == $past(rec_src_q[rpci_pkg::POS_RIGHT_SRC +: 3]))
    else $error("right source wrong");
  a_gain_left: assert property (@(posedge clk) disable iff (!rst_b) // R7
    left_chan.gain == $past(adc_gain_q[rpci_pkg::POS_LEFT_GAIN +: 4]))
    else $error("left gain wrong");
  a_gain_right: assert property (@(posedge clk) disable iff (!rst_b) // R7
    right_chan.gain == $past(adc_gain_q[rpci_pkg::POS_RIGHT_GAIN +: 4]))
    else $error("right gain wrong");
  a_mute_left: assert property (@(posedge clk) disable iff (!rst_b) // R7
    left_chan.mute == $past(adc_gain_q[rpci_pkg::POS_LEFT_MUTE]))
    else $error("left mute wrong");
  a_mute_right: assert property (@(posedge clk) disable iff (!rst_b) // R7
    right_chan.mute == $past(adc_gain_q[rpci_pkg::POS_RIGHT_MUTE]))
    else $error("right mute wrong");

  // General-purpose outputs and reserved bits
  a_mono_out: assert property (@(posedge clk) disable iff (!rst_b) // R6
    mono_from_mic == $past(gp_ctl_q[rpci_pkg::POS_MONO_SEL]))
    else $error("mono source wrong");
  a_loop_hold: assert property (@(posedge clk) disable iff (!rst_b) // R10
    adc_to_dac_loop == $past(gp_ctl_q[rpci_pkg::POS_LOOP]))
    else $error("loop output wrong");
  a_slot_pair: assert property (@(posedge clk) disable iff (!rst_b) // R11
    double_rate_slot_pair == $past(gp_ctl_q[rpci_pkg::POS_DOUBLE_RATE_SLOT_PAIR +: 2]))
    else $error("slot pair wrong");
  a_rsvd_src: assert property (@(posedge clk) disable iff (!rst_b) // R21
    (rec_src_q & ~rpci_pkg::MASK_REC_SRC) == 16'h0000)
    else $error("reserved source bits set");
  a_rsvd_gp: assert property (@(posedge clk) disable iff (!rst_b) // R21
    (gp_ctl_q & ~rpci_pkg::MASK_GP_CTL) == 16'h0000)
    else $error("reserved control bits set");

  // Paging, sense and interrupt
  a_page_out: assert property (@(posedge clk) disable iff (!rst_b) // R12
    page_select == $past(page_q))
    else $error("page output wrong");
  a_page_keep: assert property (@(posedge clk) disable iff (!rst_b) // R12
    (wr_irq && reg_wdata[3:0] == rpci_pkg::PAGE_STD) |=> page_q == rpci_pkg::PAGE_STD)
    else $error("standard page lost");
  a_sense_out: assert property (@(posedge clk) disable iff (!rst_b) // R16
    sense_active == $past(sense_q))
    else $error("sense output wrong");
  a_sense_done: assert property (@(posedge clk) disable iff (!rst_b) // R16
    (sense_end && !wr_irq) |=> !sense_q)
    else $error("sense still running");
  a_sense_cause: assert property (@(posedge clk) disable iff (!rst_b) // R17
    sense_end |=> (cause_s_q && pend_q))
    else $error("sense cause missing");
  a_gpio_cause: assert property (@(posedge clk) disable iff (!rst_b) // R17
    set_g |=> (cause_g_q && pend_q))
    else $error("gpio cause missing");
  a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b) // R14
    !unmask_q |=> !slot12_irq)
    else $error("masked interrupt sent");

  // Microphone selector
  a_dual_pair: assert property (@(posedge clk) disable iff (!rst_b) // R3
    (!msum && dual && !swap) |-> (pick_l == first_t && pick_r == second_t))
    else $error("dual routing wrong");
  a_swap_single: assert property (@(posedge clk) disable iff (!rst_b) // R5
    (!msum && !dual && swap) |-> (pick_l == second_t && pick_r == second_t))
    else $error("single swap wrong");
  a_swap_dual: assert property (@(posedge clk) disable iff (!rst_b) // R5
    (!msum && dual && swap) |-> (pick_l == second_t && pick_r == first_t))
    else $error("dual swap wrong");
  a_grp_mic: assert property (@(posedge clk) disable iff (!rst_b) // R2
    alt_grp == 3'h0 |-> (first_t == 6'h01 && second_t == 6'h02))
    else $error("mic group wrong");
  a_grp_ctr: assert property (@(posedge clk) disable iff (!rst_b) // R2
    alt_grp[2:1] == 2'h1 |-> (first_t == 6'h10 && second_t == 6'h20))
    else $error("center group wrong");
  a_grp_all: assert property (@(posedge clk) disable iff (!rst_b) // R2
    alt_grp == 3'h7 |-> (first_t == 6'h15 && second_t == 6'h2a))
    else $error("all group wrong");
endmodule

//--- rpci_pkg.sv
package rpci_pkg;
  // Register offsets
  localparam logic [6:0] ADDR_REC_SRC = 7'h1a;
  localparam logic [6:0] ADDR_ADC_GAIN = 7'h1c;
  localparam logic [6:0] ADDR_GP_CTL = 7'h20;
  localparam logic [6:0] ADDR_IRQ_PAGE = 7'h24;
  localparam logic [6:0] ADDR_MIC_CFG = 7'h74;

  // Reset values
  localparam logic [15:0] RST_REC_SRC = 16'h0000;
  localparam logic [15:0] RST_ADC_GAIN = 16'h8080;
  localparam logic [15:0] RST_GP_CTL = 16'h0000;
  localparam logic [15:0] RST_IRQ_PAGE = 16'h0000;
  localparam logic [15:0] RST_MIC_CFG = 16'h0000;

  // Write masks for implemented bits
  localparam logic [15:0] MASK_REC_SRC = 16'h0707;
  localparam logic [15:0] MASK_ADC_GAIN = 16'h8f8f;
  localparam logic [15:0] MASK_GP_CTL = 16'h0f80;
  localparam logic [15:0] MASK_MIC_CFG = 16'h0707;

  // Field positions
  localparam int POS_LEFT_SRC = 8;
  localparam int POS_RIGHT_SRC = 0;
  localparam int POS_LEFT_MUTE = 15;
  localparam int POS_LEFT_GAIN = 8;
  localparam int POS_RIGHT_MUTE = 7;
  localparam int POS_RIGHT_GAIN = 0;
  localparam int POS_LOOP = 7;
  localparam int POS_SWAP = 8;
  localparam int POS_MONO_SEL = 9;
  localparam int POS_DOUBLE_RATE_SLOT_PAIR = 10;
  localparam int POS_UNMASK = 11;
  localparam int POS_SENSE = 12;
  localparam int POS_CAUSE_SENSE = 13;
  localparam int POS_CAUSE_GPIO = 14;
  localparam int POS_PENDING = 15;
  localparam int POS_ALT_GRP = 8;
  localparam int POS_MIC_SUM = 1;
  localparam int POS_DUAL = 0;

  // Implemented register pages
  localparam logic [3:0] PAGE_VENDOR = 4'h0;
  localparam logic [3:0] PAGE_STD = 4'h1;

  // Source codes, three-bit: mic selector, CD, mute, aux, line, stereo mix, mono mix, phone
  typedef enum logic [2:0] {
    RPCI_SRC_MICSEL, RPCI_SRC_CD, RPCI_SRC_MUTE, RPCI_SRC_AUX,
    RPCI_SRC_LINE, RPCI_SRC_STMIX, RPCI_SRC_MONOMIX, RPCI_SRC_PHONE
  } rpci_src_e;

  typedef struct packed {
    logic mute;
    logic [3:0] gain;
    rpci_src_e src;
    logic [5:0] mic_terms;
  } rpci_chan_s;

  typedef struct packed {
    logic sense_done;
    logic gpio_change;
  } rpci_evt_s;
endpackage

//--- rpci_gpio_model.sv
module rpci_gpio_model (
  // Clock and request
  input wire logic clk,
  input wire logic fire,
  // Event line
  output logic gpio_change
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial gpio_change = 1'b0;
  // Level held for five cycles, moved off the clock edge as an async source
  always @(posedge clk) begin
    if (fire) cnt = 5;
    else if (cnt > 0) cnt = cnt - 1;
    #7 gpio_change = (cnt > 0);
  end
endmodule

//--- record_path_ctl_irq_tb_top.sv
module record_path_ctl_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SENSE_N = 4;
  logic clk, rst_b, reg_wr, reg_rd, fire, gpio, mono_from_mic, loop_on, sense_active, slot12_irq;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] slot_pair;
  logic [3:0] page_select;
  rpci_pkg::rpci_chan_s left_chan, right_chan;
  int n_fail = 0;
  int total_checks = 0;

  rpci_ctl #(.SENSE_CYCLES(SENSE_N)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_change_in(gpio), .left_chan(left_chan), .right_chan(right_chan),
    .mono_from_mic(mono_from_mic), .adc_to_dac_loop(loop_on),
    .double_rate_slot_pair(slot_pair), .page_select(page_select),
    .sense_active(sense_active), .slot12_irq(slot12_irq));
  rpci_gpio_model i_gpio (.clk(clk), .fire(fire), .gpio_change(gpio));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(what, exp, v);
    @(posedge clk);
    #1;
  endtask

  // Mic config and swap, then both selector outputs
  task automatic mic(input logic [15:0] cfg, input logic [15:0] gp, input logic [5:0] l,
                     input logic [5:0] r);
    wr(rpci_pkg::ADDR_MIC_CFG, cfg);
    wr(rpci_pkg::ADDR_GP_CTL, gp);
    chk("left mic terms", {10'h0, l}, {10'h0, left_chan.mic_terms});
    chk("right mic terms", {10'h0, r}, {10'h0, right_chan.mic_terms});
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fire = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    rd(rpci_pkg::ADDR_REC_SRC, 16'h0000, "rec src reset");
    rd(rpci_pkg::ADDR_ADC_GAIN, 16'h8080, "gain reset");
    rd(rpci_pkg::ADDR_GP_CTL, 16'h0000, "gp reset");
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0000, "irq page reset");
    chk("left mute", 16'h0001, {15'h0, left_chan.mute});
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wr(rpci_pkg::ADDR_REC_SRC, {5'h1f, i[2:0], 5'h1f, ~i[2:0]});
      chk("left src", {13'h0, i[2:0]}, {13'h0, left_chan.src});
      chk("right src", {13'h0, ~i[2:0]}, {13'h0, right_chan.src});
    end
    rd(rpci_pkg::ADDR_REC_SRC, 16'h0700, "rec src masked");
    $display("source test done");
    wr(rpci_pkg::ADDR_ADC_GAIN, 16'h7f85);
    rd(rpci_pkg::ADDR_ADC_GAIN, 16'h0f85, "gain masked");
    chk("left gain", 16'h000f, {11'h0, left_chan.mute, left_chan.gain});
    chk("right gain", 16'h0015, {11'h0, right_chan.mute, right_chan.gain});
    wr(rpci_pkg::ADDR_GP_CTL, 16'hffff);
    rd(rpci_pkg::ADDR_GP_CTL, 16'h0f80, "gp masked");
    chk("gp outs", 16'h000f, {12'h0, loop_on, mono_from_mic, slot_pair});
    wr(rpci_pkg::ADDR_GP_CTL, 16'h0400);
    chk("gp outs 2", 16'h0001, {12'h0, loop_on, mono_from_mic, slot_pair});
    rd(rpci_pkg::ADDR_GP_CTL, 16'h0400, "gp before merge");
    wr(rpci_pkg::ADDR_GP_CTL, 16'h0400 | 16'h0080);
    chk("gp merged", 16'h0009, {12'h0, loop_on, mono_from_mic, slot_pair});
    wr(7'h30, 16'hffff);
    rd(7'h30, 16'h0000, "unmapped");
    $display("control test done");
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h0001);
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0001, "page one");
    chk("page out", 16'h0001, {12'h0, page_select});
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h0005);
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0000, "page five");
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h1000);
    chk("sense run", 16'h0001, {15'h0, sense_active});
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h1000, "sense bit");
    repeat (SENSE_N + 6) @(posedge clk);
    #1;
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'ha000, "sense done");
    chk("masked irq", 16'h0000, {15'h0, slot12_irq});
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h0800);
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'ha800, "write zero");
    chk("unmasked irq", 16'h0001, {15'h0, slot12_irq});
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h8800);
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0800, "cleared");
    chk("irq low", 16'h0000, {15'h0, slot12_irq});
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h1000);
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h0000);
    chk("sense abort", 16'h0000, {15'h0, sense_active});
    repeat (SENSE_N + 6) @(posedge clk);
    #1;
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0000, "aborted");
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'hc000, "gpio cause");
    wr(rpci_pkg::ADDR_IRQ_PAGE, 16'h8000);
    rd(rpci_pkg::ADDR_IRQ_PAGE, 16'h0000, "gpio cleared");
    $display("interrupt test done");
    mic(16'h0000, 16'h0000, 6'h01, 6'h01);
    mic(16'h0000, 16'h0100, 6'h02, 6'h02);
    mic(16'h0001, 16'h0000, 6'h01, 6'h02);
    mic(16'h0001, 16'h0100, 6'h02, 6'h01);
    mic(16'h0003, 16'h0100, 6'h03, 6'h03);
    mic(16'h0100, 16'h0000, 6'h04, 6'h04);
    mic(16'h0300, 16'h0000, 6'h10, 6'h10);
    mic(16'h0701, 16'h0000, 6'h15, 6'h2a);
    mic(16'h0702, 16'h0000, 6'h3f, 6'h3f);
    $display("selector test done");
    conclude();
  end
endmodule
